//--- rtl/imc_i2c_master.sv
// Purpose: two-wire bus master transaction sequencer
// Assumes: sole master; pins are open drain, oe high pulls low
// Notes: control and status bits are plain ports, no register bus
//
// Overview of operation
// (RULE1) start: pull data low, clock high
// (RULE2) stop: release data low-high, clock high
// (RULE3) separate start and stop request bits
// (RULE4) start instead of stop gives restart
// (RULE5) start waits for request and data byte
// (RULE6) write stalls before ack when buffer empty
// (RULE7) stalled ack clock resumes with next byte
// (RULE8) no stall when start or stop pending
// (RULE9) nack sets flag, holds until start/stop
// (RULE10) flush drops stale byte, re-enables tx irq
// (RULE11) read stalls after ack until rx consumed
// (RULE12) dma reads n-1, software nacks last
// (RULE13) three status flags raise interrupt
// (RULE14) software gates tx irq per transaction
// (RULE15) ack status unreliable mid-transaction
// (RULE16) empty on transfer, cleared by write
`include "imc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module imc_i2c_master #(
   parameter int QTR_CYC = `IMC_QTR_CYC,
   parameter int DEPTH = `IMC_FIFO_DEPTH
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic ce_i,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe_o,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic start_set_i,
   input wire logic stop_set_i,
   input wire logic flush_i,
   input wire logic nack_send_i,
   input wire logic tx_irq_enable_i,
   input wire logic nack_clr_i,
   input wire logic [`IMC_DATA_W-1:0] tx_data_i,
   input wire logic tx_valid_i,
   output logic tx_ready_o,
   output logic [`IMC_DATA_W-1:0] rx_data_o,
   input wire logic rx_read_i,
   output logic tx_empty_flag_o,
   output logic rx_full_flag_o,
   output logic nack_irq_flag_o,
   output logic ack_o,
   output logic start_req_o,
   output logic stop_req_o,
   output logic irq_o
);
   localparam logic [7:0] QTR_M1 = 8'(QTR_CYC - 1);

   logic [1:0] rst_sync_q;
   logic rst_n;
   logic [1:0] pin_s;
   logic scl_s, sda_s;
   logic f_valid, pop;
   logic [`IMC_DATA_W-1:0] f_data;

   imc_pkg::imc_state_t st_q, st_d;
   logic [7:0] cnt_q, cnt_d;
   logic [1:0] ph_q, ph_d;
   logic [2:0] bit_q, bit_d;
   logic [`IMC_DATA_W-1:0] sh_q, sh_d, rx_q, rx_d;
   logic rw_q, rw_d, first_q, first_d;
   logic scl_oe_q, scl_oe_d, sda_oe_q, sda_oe_d;
   logic ack_q, ack_d;
   logic start_req_q, start_req_d, stop_req_q, stop_req_d;
   logic nack_q, nack_d, rx_full_q, rx_full_d;
   logic tx_empty_q, tx_empty_d, irq_q, irq_d;
   logic drv_lvl_q;
   logic adv, timed, rd;
   logic start_clr, stop_clr, nack_set, rx_set;

   // reset asserts at once, releases after two edges
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   imc_sync #(.W(2)) u_sync (
      .clk_i(clk_i),
      .rst_n_i(rst_n),
      .ce_i(ce_i),
      .d_i({scl_i, sda_i}),
      .q_o(pin_s)
   );
   assign scl_s = pin_s[1];
   assign sda_s = pin_s[0];

   imc_fifo #(.W(`IMC_DATA_W), .DEPTH(DEPTH)) u_fifo (
      .clk_i(clk_i),
      .rst_n_i(rst_n),
      .ce_i(ce_i),
      .flush_i(flush_i), // [RULE10]
      .in_valid_i(tx_valid_i),
      .in_ready_o(tx_ready_o),
      .in_data_i(tx_data_i),
      .out_valid_o(f_valid),
      .out_ready_i(pop),
      .out_data_o(f_data)
   );

   // read data phase: after a read address byte
   assign rd = rw_q && !first_q;
   assign timed = (st_q == imc_pkg::ST_START) || (st_q == imc_pkg::ST_BITS) ||
                  (st_q == imc_pkg::ST_ACK) || (st_q == imc_pkg::ST_STOP);

   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      ph_d = ph_q;
      bit_d = bit_q;
      sh_d = sh_q;
      rx_d = rx_q;
      rw_d = rw_q;
      first_d = first_q;
      scl_oe_d = scl_oe_q;
      sda_oe_d = sda_oe_q;
      ack_d = ack_q;
      pop = 1'b0;
      start_clr = 1'b0;
      stop_clr = 1'b0;
      nack_set = 1'b0;
      rx_set = 1'b0;
      adv = 1'b0;
      // a slave holding clock low stretches the high quarter
      if (timed && !(ph_q == 2'd2 && !scl_s)) begin
         if (cnt_q == QTR_M1) begin
            cnt_d = '0;
            adv = 1'b1;
            ph_d = ph_q + 2'd1;
         end else begin
            cnt_d = cnt_q + 8'd1;
         end
      end
      case (st_q)
         imc_pkg::ST_IDLE: begin
            cnt_d = '0;
            ph_d = '0;
            if (start_req_q && f_valid) begin
               st_d = imc_pkg::ST_START; // [RULE5]
            end
         end
         imc_pkg::ST_START: begin
            if (adv) begin
               case (ph_q)
                  2'd0: sda_oe_d = 1'b0;
                  2'd1: scl_oe_d = 1'b0;
                  2'd2: begin
                     if (f_valid) begin
                        sda_oe_d = 1'b1; // [RULE1]
                     end else begin
                        ph_d = ph_q; // [RULE5]
                     end
                  end
                  default: begin
                     scl_oe_d = 1'b1;
                     pop = 1'b1;
                     sh_d = f_data;
                     rw_d = f_data[0];
                     first_d = 1'b1;
                     bit_d = '0;
                     start_clr = 1'b1;
                     st_d = imc_pkg::ST_BITS;
                  end
               endcase
            end
         end
         imc_pkg::ST_BITS: begin
            if (adv) begin
               case (ph_q)
                  2'd0: sda_oe_d = rd ? 1'b0 : !sh_q[7];
                  2'd1: scl_oe_d = 1'b0;
                  2'd2: sh_d = {sh_q[6:0], sda_s};
                  default: begin
                     scl_oe_d = 1'b1;
                     bit_d = bit_q + 3'd1;
                     if (bit_q == 3'd7) begin
                        if (!rw_q && !f_valid && !start_req_q && !stop_req_q) begin
                           st_d = imc_pkg::ST_WSTALL; // [RULE6] [RULE8]
                        end else begin
                           st_d = imc_pkg::ST_ACK;
                        end
                     end
                  end
               endcase
            end
         end
         imc_pkg::ST_ACK: begin
            if (adv) begin
               case (ph_q)
                  2'd0: sda_oe_d = rd ? !nack_send_i : 1'b0; // [RULE12]
                  2'd1: scl_oe_d = 1'b0;
                  2'd2: ack_d = !sda_s; // [RULE15]
                  default: begin
                     scl_oe_d = 1'b1;
                     if (rd) begin
                        rx_d = sh_q;
                        rx_set = 1'b1;
                        st_d = imc_pkg::ST_RSTALL; // [RULE11]
                     end else if (!ack_q) begin
                        nack_set = 1'b1;
                        st_d = imc_pkg::ST_NHOLD; // [RULE9]
                     end else if (first_q && rw_q) begin
                        first_d = 1'b0;
                        bit_d = '0;
                        st_d = imc_pkg::ST_BITS;
                     end else if (stop_req_q) begin
                        st_d = imc_pkg::ST_STOP;
                     end else if (start_req_q) begin
                        st_d = imc_pkg::ST_START; // [RULE4]
                     end else if (f_valid) begin
                        pop = 1'b1; // [RULE16]
                        sh_d = f_data;
                        first_d = 1'b0;
                        bit_d = '0;
                        st_d = imc_pkg::ST_BITS;
                     end else begin
                        // flushed under us: wait with clock low
                        ph_d = ph_q;
                     end
                  end
               endcase
            end
         end
         imc_pkg::ST_WSTALL: begin
            cnt_d = '0;
            ph_d = '0;
            if (f_valid || start_req_q || stop_req_q) begin
               st_d = imc_pkg::ST_ACK; // [RULE7]
            end
         end
         imc_pkg::ST_NHOLD: begin
            cnt_d = '0;
            ph_d = '0;
            if (stop_req_q) begin
               st_d = imc_pkg::ST_STOP; // [RULE9]
            end else if (start_req_q) begin
               st_d = imc_pkg::ST_START; // [RULE4]
            end
         end
         imc_pkg::ST_RSTALL: begin
            cnt_d = '0;
            ph_d = '0;
            if (!rx_full_q) begin // [RULE11]
               if (stop_req_q) begin
                  st_d = imc_pkg::ST_STOP;
               end else if (start_req_q) begin
                  st_d = imc_pkg::ST_START; // [RULE4]
               end else begin
                  bit_d = '0;
                  st_d = imc_pkg::ST_BITS;
               end
            end
         end
         imc_pkg::ST_STOP: begin
            if (adv) begin
               case (ph_q)
                  2'd0: sda_oe_d = 1'b1;
                  2'd1: scl_oe_d = 1'b0;
                  2'd2: sda_oe_d = 1'b0; // [RULE2]
                  default: begin
                     stop_clr = 1'b1;
                     st_d = imc_pkg::ST_IDLE;
                  end
               endcase
            end
         end
         default: begin
            st_d = imc_pkg::ST_IDLE;
         end
      endcase
   end

   // flags: a set in the same cycle as a clear wins
   always_comb begin
      start_req_d = start_set_i | (start_req_q & ~start_clr); // [RULE3]
      stop_req_d = stop_set_i | (stop_req_q & ~stop_clr); // [RULE3]
      nack_d = nack_set | (nack_q & ~nack_clr_i); // [RULE9]
      rx_full_d = rx_set | (rx_full_q & ~rx_read_i);
      tx_empty_d = !f_valid; // [RULE16]
      irq_d = nack_q | rx_full_q | (tx_empty_q & tx_irq_enable_i); // [RULE13] [RULE14]
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= imc_pkg::ST_IDLE;
         cnt_q <= '0;
         ph_q <= '0;
         bit_q <= '0;
         sh_q <= '0;
         rx_q <= '0;
         rw_q <= `IMC_RST_ZERO;
         first_q <= `IMC_RST_ZERO;
         scl_oe_q <= `IMC_RST_ZERO;
         sda_oe_q <= `IMC_RST_ZERO;
         ack_q <= `IMC_RST_ZERO;
         start_req_q <= `IMC_RST_ZERO;
         stop_req_q <= `IMC_RST_ZERO;
         nack_q <= `IMC_RST_ZERO;
         rx_full_q <= `IMC_RST_ZERO;
         tx_empty_q <= 1'b1;
         irq_q <= `IMC_RST_ZERO;
         drv_lvl_q <= `IMC_RST_ZERO;
      end else if (ce_i) begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         ph_q <= ph_d;
         bit_q <= bit_d;
         sh_q <= sh_d;
         rx_q <= rx_d;
         rw_q <= rw_d;
         first_q <= first_d;
         scl_oe_q <= scl_oe_d;
         sda_oe_q <= sda_oe_d;
         ack_q <= ack_d;
         start_req_q <= start_req_d;
         stop_req_q <= stop_req_d;
         nack_q <= nack_d;
         rx_full_q <= rx_full_d;
         tx_empty_q <= tx_empty_d;
         irq_q <= irq_d;
         drv_lvl_q <= `IMC_RST_ZERO;
      end
   end

   // open drain: only ever pulls low
   assign scl_o = drv_lvl_q;
   assign sda_o = drv_lvl_q;
   assign scl_oe_o = scl_oe_q;
   assign sda_oe_o = sda_oe_q;
   assign rx_data_o = rx_q;
   assign tx_empty_flag_o = tx_empty_q;
   assign rx_full_flag_o = rx_full_q;
   assign nack_irq_flag_o = nack_q;
   assign ack_o = ack_q;
   assign start_req_o = start_req_q;
   assign stop_req_o = stop_req_q;
   assign irq_o = irq_q;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n);

   property p_start_cond;
      $rose(sda_oe_o) && st_q == imc_pkg::ST_START |-> !scl_oe_o;
   endproperty
   a_start_cond: assert property (p_start_cond) else $error("start without clock high"); // [RULE1]

   property p_stop_cond;
      $fell(sda_oe_o) && st_q == imc_pkg::ST_STOP |-> !scl_oe_o;
   endproperty
   a_stop_cond: assert property (p_stop_cond) else $error("stop without clock high"); // [RULE2]

   property p_start_gate;
      st_q == imc_pkg::ST_IDLE && !(start_req_q && f_valid) && ce_i |=> st_q == imc_pkg::ST_IDLE;
   endproperty
   a_start_gate: assert property (p_start_gate) else $error("start left idle early"); // [RULE5]

   property p_repstart;
      st_q == imc_pkg::ST_NHOLD && start_req_q && !stop_req_q && ce_i
         |=> st_q == imc_pkg::ST_START && scl_oe_o;
   endproperty
   a_repstart: assert property (p_repstart) else $error("restart not issued"); // [RULE4]

   property p_wstall;
      st_q == imc_pkg::ST_WSTALL && !f_valid && !start_req_q && !stop_req_q && ce_i
         |=> st_q == imc_pkg::ST_WSTALL && scl_oe_o;
   endproperty
   a_wstall: assert property (p_wstall) else $error("write stall released early"); // [RULE6]

   property p_release;
      st_q == imc_pkg::ST_WSTALL && f_valid && ce_i |=> st_q == imc_pkg::ST_ACK && ph_q == 2'd0;
   endproperty
   a_release: assert property (p_release) else $error("ack clock not resumed"); // [RULE7]

   property p_nostall;
      st_q == imc_pkg::ST_BITS && (start_req_q || stop_req_q) && ce_i
         |=> st_q != imc_pkg::ST_WSTALL;
   endproperty
   a_nostall: assert property (p_nostall) else $error("stalled with start or stop set"); // [RULE8]

   property p_nack;
      st_q == imc_pkg::ST_ACK && adv && ph_q == 2'd3 && !rd && !ack_q && ce_i
         |=> nack_irq_flag_o && st_q == imc_pkg::ST_NHOLD ##1 irq_o || !ce_i;
   endproperty
   a_nack: assert property (p_nack) else $error("nack not flagged"); // [RULE9]

   property p_nhold;
      st_q == imc_pkg::ST_NHOLD && !start_req_q && !stop_req_q && ce_i
         |=> st_q == imc_pkg::ST_NHOLD;
   endproperty
   a_nhold: assert property (p_nhold) else $error("nack hold left early"); // [RULE9]

   property p_flush;
      (flush_i && ce_i) ##1 ce_i |=> tx_empty_flag_o;
   endproperty
   a_flush: assert property (p_flush) else $error("flush left data"); // [RULE10]

   property p_rstall;
      st_q == imc_pkg::ST_RSTALL && rx_full_q && ce_i |=> st_q == imc_pkg::ST_RSTALL && scl_oe_o;
   endproperty
   a_rstall: assert property (p_rstall) else $error("read stall released early"); // [RULE11]

   property p_irq;
      (rx_full_q || nack_q) && ce_i |=> irq_o;
   endproperty
   a_irq: assert property (p_irq) else $error("flag without interrupt"); // [RULE13]

   property p_txempty;
      (tx_valid_i && tx_ready_o && !flush_i && ce_i) ##1 (ce_i && !flush_i) |=> !tx_empty_flag_o;
   endproperty
   a_txempty: assert property (p_txempty) else $error("write left empty flag"); // [RULE16]

   c_wstall: cover property (st_q == imc_pkg::ST_WSTALL ##1 st_q == imc_pkg::ST_ACK);
   c_nack: cover property (st_q == imc_pkg::ST_NHOLD);
   c_read: cover property (rx_set && ce_i);
   c_restart: cover property (st_q == imc_pkg::ST_ACK ##1 st_q == imc_pkg::ST_START);
endmodule
`default_nettype wire

//--- shared/imc_defs.svh
// Purpose: constants for the two-wire master transaction controller
// Assumes: 10 MHz system clock
// Notes: quarter-bit time gives a 100 kHz bus rate
`ifndef IMC_DEFS_SVH
`define IMC_DEFS_SVH

`define IMC_CLK_NS 100
`define IMC_QTR_NS 2500
// least time, so round up
`define IMC_QTR_CYC ((`IMC_QTR_NS + `IMC_CLK_NS - 1) / `IMC_CLK_NS)
`define IMC_DATA_W 8
`define IMC_FIFO_DEPTH 8
`define IMC_RST_ZERO 1'b0

`endif

//--- shared/imc_pkg.sv
// Purpose: types for the two-wire master transaction controller
// Assumes: nothing
// Notes: states of the byte-level sequencer
package imc_pkg;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_START,
      ST_BITS,
      ST_ACK,
      ST_WSTALL,
      ST_NHOLD,
      ST_RSTALL,
      ST_STOP
   } imc_state_t;
endpackage

//--- rtl/imc_sync.sv
// Purpose: two-stage synchroniser for pin levels
// Assumes: inputs come from outside the clock domain
// Notes: first stage is read only by the second
`timescale 1ns/1ps
`default_nettype none
module imc_sync #(
   parameter int W = 2
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;

   // idle bus level is high
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s1_q <= '1;
         s2_q <= '1;
      end else if (ce_i) begin
         s1_q <= d_i;
         s2_q <= s1_q;
      end
   end

   assign q_o = s2_q;
endmodule
`default_nettype wire

//--- rtl/imc_fifo.sv
// Purpose: transmit data buffer between software and the shifter
// Assumes: single clock, flush wins over push and pop
// Notes: ready is a registered not-full flag
`timescale 1ns/1ps
`default_nettype none
module imc_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 8
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic flush_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [W-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [W-1:0] mem_q [DEPTH];
   logic [W-1:0] mem_d [DEPTH];
   logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [AW:0] cnt_q, cnt_d;
   logic nfull_q, nfull_d;
   logic push, pop;

   function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
      nxt = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   assign push = in_valid_i && nfull_q;
   assign pop = out_ready_i && (cnt_q != '0);

   always_comb begin
      mem_d = mem_q;
      wr_d = wr_q;
      rd_d = rd_q;
      cnt_d = cnt_q;
      if (flush_i) begin
         wr_d = '0;
         rd_d = '0;
         cnt_d = '0;
      end else begin
         if (push) begin
            mem_d[wr_q] = in_data_i;
            wr_d = nxt(wr_q);
         end
         if (pop) begin
            rd_d = nxt(rd_q);
         end
         cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
      nfull_d = (cnt_d != (AW+1)'(DEPTH));
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mem_q <= '{default: '0};
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
         nfull_q <= 1'b1;
      end else if (ce_i) begin
         mem_q <= mem_d;
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
         nfull_q <= nfull_d;
      end
   end

   assign in_ready_o = nfull_q;
   assign out_valid_o = (cnt_q != '0);
   assign out_data_o = mem_q[rd_q];
endmodule
`default_nettype wire

//--- verif/imc_slave_model.sv
// Purpose: behavioural bus slave facing the master sequencer
// Assumes: open-drain wires with pull-ups; sda_oe_o high pulls data low
// Notes: acks when ack_en_i is high, returns rd_byte_i on reads
`timescale 1ns/1ps
`default_nettype none
module imc_slave_model (
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic ack_en_i,
   input wire logic [7:0] rd_byte_i,
   output logic sda_oe_o,
   output logic [7:0] last_byte_o,
   output int byte_cnt_o,
   output int clk_cnt_o,
   output int start_cnt_o,
   output int stop_cnt_o
);
   int idx = 0;
   logic addr = 1'b0;
   logic rd = 1'b0;
   logic quiet = 1'b0;
   logic [7:0] sh = 8'h00;
   initial begin
      sda_oe_o = 1'b0;
      last_byte_o = 8'h00;
      byte_cnt_o = 0;
      clk_cnt_o = 0;
      start_cnt_o = 0;
      stop_cnt_o = 0;
   end
   // a start or restart resets the bit counter
   always @(negedge sda_i) if (scl_i === 1'b1) begin
      // the clock fall that ends the start is not a bit
      idx = -1;
      addr = 1'b1;
      rd = 1'b0;
      quiet = 1'b0;
      start_cnt_o++;
   end
   always @(posedge sda_i) if (scl_i === 1'b1) begin
      stop_cnt_o++;
   end
   always @(posedge scl_i) begin
      clk_cnt_o++;
      if (idx < 8) sh = {sh[6:0], sda_i};
      else if (rd && !addr && sda_i) quiet = 1'b1;
   end
   // data only changes while the clock is low, so no false start or stop
   always @(negedge scl_i) begin
      if (idx == 7) begin
         last_byte_o = sh;
         byte_cnt_o++;
         if (addr) rd = sh[0];
      end
      if (idx == 8) addr = 1'b0;
      idx = (idx == 8) ? 0 : idx + 1;
      if (idx == 8) sda_oe_o = (addr || !rd) && ack_en_i && !quiet;
      else sda_oe_o = rd && !addr && !quiet && !rd_byte_i[7 - idx];
   end
endmodule
`default_nettype wire

//--- verif/tb_top.sv
// Purpose: self-checking bench for the two-wire master sequencer
// Assumes: QTR_CYC 2 gives a 1000 ns bus bit at the 100 ns clock, the high quarter held two more cycles by the pin sync
// Notes: both wires open drain with pull-ups, resolved here
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
   $display("wrong value %s exp %0h got %0h", nm, e, g); end end
`define WAITC(c) for (int i = 0; i < 3000 && !(c); i++) @(negedge clk_i);
module tb_top;
   logic clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic start_set_i = 1'b0;
   logic stop_set_i = 1'b0;
   logic flush_i = 1'b0;
   logic nack_send_i = 1'b0;
   logic txie = 1'b0;
   logic nack_clr_i = 1'b0;
   logic tx_valid_i = 1'b0;
   logic rx_read_i = 1'b0;
   logic ack_en = 1'b1;
   logic [7:0] tx_data_i = 8'h00;
   logic scl_o, scl_oe_o, sda_o, sda_oe_o, s_oe, tx_ready_o, tx_empty_flag_o;
   logic rx_full_flag_o, nack_irq_flag_o, ack_o, start_req_o, stop_req_o, irq_o;
   logic [7:0] rx_data_o, s_last;
   int s_byte, s_clk, s_start, s_stop, b0, c0, st0, sp0;
   int bad_count = 0;
   int total_checks = 0;
   int cyc = 0;
   wire scl_w = !scl_oe_o;
   wire sda_w = !(sda_oe_o || s_oe);
   always #50 clk_i = ~clk_i;
   imc_i2c_master #(.QTR_CYC(2), .DEPTH(8)) u_dut (.clk_i(clk_i), .arst_n_i(arst_n_i),
      .ce_i(1'b1), .scl_i(scl_w), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda_w),
      .sda_o(sda_o), .sda_oe_o(sda_oe_o), .start_set_i(start_set_i),
      .stop_set_i(stop_set_i), .flush_i(flush_i), .nack_send_i(nack_send_i),
      .tx_irq_enable_i(txie), .nack_clr_i(nack_clr_i), .tx_data_i(tx_data_i),
      .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o), .rx_data_o(rx_data_o),
      .rx_read_i(rx_read_i), .tx_empty_flag_o(tx_empty_flag_o),
      .rx_full_flag_o(rx_full_flag_o), .nack_irq_flag_o(nack_irq_flag_o), .ack_o(ack_o),
      .start_req_o(start_req_o), .stop_req_o(stop_req_o), .irq_o(irq_o));
   imc_slave_model u_slave (.scl_i(scl_w), .sda_i(sda_w), .ack_en_i(ack_en),
      .rd_byte_i(8'hc3), .sda_oe_o(s_oe), .last_byte_o(s_last), .byte_cnt_o(s_byte),
      .clk_cnt_o(s_clk), .start_cnt_o(s_start), .stop_cnt_o(s_stop));
   task automatic test_done();
      if (bad_count == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // long enough for all scenarios several times over
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 30000) begin
         bad_count++;
         test_done();
      end
   end
   task automatic wt(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   task automatic base();
      b0 = s_byte;
      c0 = s_clk;
      st0 = s_start;
      sp0 = s_stop;
   endtask
   task automatic go(input logic s, input logic p, input logic f);
      @(posedge clk_i);
      start_set_i <= s;
      stop_set_i <= p;
      flush_i <= f;
      @(posedge clk_i);
      start_set_i <= 1'b0;
      stop_set_i <= 1'b0;
      flush_i <= 1'b0;
      @(negedge clk_i);
   endtask
   task automatic push(input logic [7:0] b);
      @(posedge clk_i);
      tx_data_i <= b;
      tx_valid_i <= 1'b1;
      @(posedge clk_i);
      tx_valid_i <= 1'b0;
      @(negedge clk_i);
   endtask
   task automatic t_reset();
      `CHK("tx_empty", 1'b1, tx_empty_flag_o)
      `CHK("sda_oe", 1'b0, sda_oe_o)
      `CHK("irq", 1'b0, irq_o)
      `CHK("scl_lvl", 1'b0, scl_o)
      `CHK("sda_lvl", 1'b0, sda_o)
      @(posedge clk_i) txie <= 1'b1;
      wt(3);
      `CHK("irq_tx", 1'b1, irq_o)
      @(posedge clk_i) txie <= 1'b0;
      wt(3);
      `CHK("irq_off", 1'b0, irq_o)
   endtask
   task automatic t_fill();
      for (int k = 0; k < 9; k++) push(8'h10 + 8'(k));
      wt(2);
      `CHK("tx_ready_full", 1'b0, tx_ready_o)
      `CHK("tx_empty_full", 1'b0, tx_empty_flag_o)
      go(1'b0, 1'b0, 1'b1);
      wt(3);
      `CHK("tx_empty_flush", 1'b1, tx_empty_flag_o)
      `CHK("tx_ready_flush", 1'b1, tx_ready_o)
   endtask
   task automatic t_write();
      base();
      go(1'b1, 1'b0, 1'b0);
      wt(50);
      `CHK("start_req", 1'b1, start_req_o)
      `CHK("no_start", 0, s_start - st0)
      `CHK("sda_idle", 1'b1, sda_w)
      push(8'ha0);
      `WAITC(s_byte > b0)
      wt(40);
      `CHK("start_seen", 1, s_start - st0)
      `CHK("addr", 8'ha0, s_last)
      `CHK("tx_empty_pop", 1'b1, tx_empty_flag_o)
      `CHK("stall_clks", 8, s_clk - c0)
      `CHK("stall_scl", 1'b0, scl_w)
      push(8'h5a);
      `WAITC(s_byte > b0 + 1)
      wt(40);
      `CHK("data", 8'h5a, s_last)
      `CHK("ack_grouped", 17, s_clk - c0)
   endtask
   task automatic t_stop();
      base();
      go(1'b0, 1'b1, 1'b0);
      `WAITC(s_stop > sp0)
      wt(5);
      `CHK("ack_then_stop", 2, s_clk - c0)
      `CHK("stop_seen", 1, s_stop - sp0)
      `CHK("stop_req", 1'b0, stop_req_o)
      `CHK("idle_sda", 1'b1, sda_w)
      `CHK("ack_end", 1'b1, ack_o)
   endtask
   task automatic t_nack();
      ack_en <= 1'b0;
      push(8'ha0);
      push(8'h33);
      base();
      go(1'b1, 1'b0, 1'b0);
      `WAITC(nack_irq_flag_o === 1'b1)
      wt(30);
      `CHK("nack_flag", 1'b1, nack_irq_flag_o)
      `CHK("nack_irq", 1'b1, irq_o)
      `CHK("nack_hold", 9, s_clk - c0)
      `CHK("nack_ack", 1'b0, ack_o)
      `CHK("stale", 1'b0, tx_empty_flag_o)
      go(1'b0, 1'b1, 1'b1);
      `WAITC(s_stop > sp0)
      wt(5);
      `CHK("nack_stop", 1, s_stop - sp0)
      `CHK("flushed", 1'b1, tx_empty_flag_o)
      @(posedge clk_i) txie <= 1'b1;
      nack_clr_i <= 1'b1;
      @(posedge clk_i) nack_clr_i <= 1'b0;
      wt(3);
      `CHK("nack_clr", 1'b0, nack_irq_flag_o)
      `CHK("tx_irq_back", 1'b1, irq_o)
      @(posedge clk_i) txie <= 1'b0;
      ack_en <= 1'b1;
   endtask
   task automatic t_read();
      @(posedge clk_i) nack_send_i <= 1'b1;
      push(8'ha0);
      base();
      go(1'b1, 1'b0, 1'b0);
      `WAITC(s_byte > b0)
      push(8'h5a);
      `WAITC(s_clk - c0 >= 10)
      push(8'ha1);
      go(1'b1, 1'b0, 1'b0);
      `WAITC(rx_full_flag_o === 1'b1)
      wt(3);
      `CHK("restart", 2, s_start - st0)
      `CHK("no_stop", 0, s_stop - sp0)
      `CHK("rx_data", 8'hc3, rx_data_o)
      `CHK("rx_irq", 1'b1, irq_o)
      c0 = s_clk;
      go(1'b0, 1'b1, 1'b0);
      wt(30);
      `CHK("rx_stall", 0, s_clk - c0)
      `CHK("rx_stall_stop", 0, s_stop - sp0)
      @(posedge clk_i) rx_read_i <= 1'b1;
      @(posedge clk_i) rx_read_i <= 1'b0;
      `WAITC(s_stop > sp0)
      wt(3);
      `CHK("rx_clear", 1'b0, rx_full_flag_o)
      `CHK("read_stop", 1, s_stop - sp0)
   endtask
   initial begin
      repeat (5) @(posedge clk_i);
      arst_n_i <= 1'b1;
      wt(4);
      t_reset();
      t_fill();
      t_write();
      t_stop();
      t_nack();
      t_read();
      test_done();
   end
endmodule
`default_nettype wire
